// [hw/chs_pkg.sv]
// package of constants and types shared by the card and host strobe ends
// Functional notes
// - io mode ack only when selected reading
// - host gates input buffers with ack; the host here samples the bus every pulse cycle and ack only sets ACK_SEEN
// - memory mode ignores io strobes, ack unused; here an io write to an odd attribute word writes the configuration word
// - drive io read data only during strobe
// - write strobe pulse writes card registers
// - capture write data on trailing edge
// - ide mode io strobes as io mode
// - host leaves ack unconnected in ide
// - memory mode output enable returns data
// - io mode output enable reads config only
// - low mode select input means ide mode
// - ready high when idle, low when busy
// - ready low until reset processing done
// - host makes no access while busy
// - reset held from power-up gets ignored
// - selected only when a card enable low
// - attribute select high common, low attribute
// - host holds attribute select low for io
package chs_pkg;
    localparam int         DATA_W        = 16;
    localparam int         ADDR_W        = 4;
    localparam int         DEPTH         = 16;
    localparam int         BUSY_CYCLES   = 64;    // reset processing time in clocks
    localparam int         STUCK_CYCLES  = 4096;  // reset held this long from power-up is disabled
    localparam int         HOLD_CYCLES   = 4;     // host strobe hold in clocks
    localparam logic [15:0] MEM_RESET    = 16'h0000;
    localparam logic [15:0] ATTR_RESET   = 16'h0041;  // attribute word reset value, arbitrary
    localparam logic [15:0] CFG_RESET    = 16'h0000;  // configuration word reset value

    typedef enum logic [1:0] {
        CHS_MODE_MEM = 2'h0,
        CHS_MODE_IO  = 2'h1,
        CHS_MODE_IDE = 2'h3
    } chs_mode_t;

    typedef enum logic [2:0] {
        CHS_H_IDLE  = 3'h0,
        CHS_H_SETUP = 3'h1,
        CHS_H_PULSE = 3'h3,
        CHS_H_HOLD  = 3'h2,
        CHS_H_DONE  = 3'h6
    } chs_hstate_t;

    typedef enum logic [1:0] {
        CHS_OP_MEMRD = 2'h0,
        CHS_OP_ATTRD = 2'h1,
        CHS_OP_IO_READ_STROBE_N  = 2'h2,
        CHS_OP_IO_WRITE_STROBE_N  = 2'h3
    } chs_op_t;
endpackage

// [hw/chs_if.sv]
// pin level connection between host and card strobe ends
interface chs_if;
    logic        card_enable_even_n;
    logic        card_enable_odd_n;
    logic        attr_select_n;
    logic        output_enable_n;     // doubles as ide_mode_select_n
    logic        io_read_strobe_n;
    logic        io_write_strobe_n;
    logic [3:0]  addr;
    logic [15:0] data_host_out;
    logic        data_host_oe_n;
    logic [15:0] data_card_out;
    logic        data_card_oe_n;
    logic        input_ack_n;
    logic        ready;
    logic        reset_pin;
    logic [15:0] data_bus;

    // wire level: card drivers win over host drivers when both are enabled, else idle high
    assign data_bus = !data_card_oe_n ? data_card_out : (!data_host_oe_n ? data_host_out : 16'hffff);

    modport card (
        input  card_enable_even_n, card_enable_odd_n, attr_select_n, output_enable_n,
        input  io_read_strobe_n, io_write_strobe_n, addr, data_bus, reset_pin,
        output data_card_out, data_card_oe_n, input_ack_n, ready
    );
    modport host (
        output card_enable_even_n, card_enable_odd_n, attr_select_n, output_enable_n,
        output io_read_strobe_n, io_write_strobe_n, addr, data_host_out, data_host_oe_n, reset_pin,
        input  data_bus, input_ack_n, ready
    );
endinterface

// [hw/chs_sync.sv]
// two flop synchroniser with rising edge pulse for a bundle of strobes
module chs_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst_n,  // synchronous reset, active low
    input  wire logic [W-1:0] d,      // asynchronous inputs, idle high
    output logic      [W-1:0] q,      // synchronised level
    output logic      [W-1:0] rise    // one cycle pulse on low to high
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } chs_sync_t;
    chs_sync_t r_q, r_d;

    // first stage feeds only the second stage
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        if (!rst_n)
        begin
            r_d = '{s1: '1, s2: '1, s3: '1};
        end
    end

    always_ff @(posedge clk)
    begin
        r_q <= r_d;
    end

    assign q    = r_q.s2;
    assign rise = r_q.s2 & ~r_q.s3;
endmodule

// [hw/chs_card.sv]
// card end: strobe sampling, mode, ack, data drive, ready and reset handling
module chs_card (
    input  wire logic  MCLK,                 // system clock, 250 MHz
    input  wire logic  RST_N,                // power-up reset, synchronous, active low
    chs_if.card        BUS,                  // host side pins
    output logic [1:0] MODE,                 // current operating mode
    output logic       WR_EVENT,             // pulse: a register was written
    output logic [3:0] WR_ADDR,              // address of last write
    output logic [15:0] WR_DATA              // data of last write
);
    localparam int SN = 3;

    typedef struct packed {
        // mode and configuration
        chs_pkg::chs_mode_t mode;
        logic               io_cfg;        // io interface configured by software
        // power-up and reset pin processing
        logic [12:0]        busy_cnt;
        logic               ready;
        logic               reset_dis;
        logic [12:0]        stuck_cnt;
        logic               reset_seen_low;
        // answer toward the host
        logic               ack_n;
        logic               oe_n;
        logic [15:0]        dout;
        // write capture
        logic               wr_ev;
        logic [3:0]         wr_addr;
        logic [15:0]        wr_data;
        logic [15:0]        wr_latch;
        logic [3:0]         addr_latch;
        // storage: flops indexed by address
        logic [15:0]        cfg;
        logic [15:0]        attr;
        logic [chs_pkg::DEPTH-1:0][15:0] mem;
    } chs_card_t;
    chs_card_t c_q, c_d;

    logic [SN-1:0] s_lvl;
    logic [SN-1:0] s_rise;
    logic          selected;
    logic          rd_io;
    logic          rd_oe;
    logic          io_like;

    // bit 0 output enable, bit 1 io read, bit 2 io write; all idle high
    chs_sync #(.W(SN)) u_sync (
        .clk   (MCLK),
        .rst_n (RST_N),
        .d     ({BUS.io_write_strobe_n, BUS.io_read_strobe_n, BUS.output_enable_n}),
        .q     (s_lvl),
        .rise  (s_rise)
    );

    // decode of synchronised strobes; card enables are used raw, since the host
    // holds them across the whole strobe and beyond the synchroniser delay
    assign selected = !BUS.card_enable_even_n || !BUS.card_enable_odd_n;
    assign io_like  = c_q.mode != chs_pkg::CHS_MODE_MEM;
    assign rd_io    = selected && io_like && !s_lvl[1];
    assign rd_oe    = selected && c_q.mode != chs_pkg::CHS_MODE_IDE && !s_lvl[0];

    // read mux shared by both read paths; attribute space only counts for
    // output enable reads, as attribute select is also low in io cycles
    function automatic logic [15:0] rd_word(input chs_card_t c, input logic attr_n, input logic oe);
        if (oe && !attr_n)
            rd_word = (BUS.addr[0]) ? c.cfg : c.attr;
        else if (oe && c.mode == chs_pkg::CHS_MODE_IO)
            rd_word = 16'h0000;
        else
            rd_word = c.mem[BUS.addr];
    endfunction

    // one step of a 13 bit cycle counter
    function automatic logic [12:0] step13(input logic [12:0] v);
        step13 = v + 13'h0001;
    endfunction

    // ide mode holds until a reset; otherwise the configuration bit decides
    function automatic chs_pkg::chs_mode_t next_mode(input chs_card_t c, input logic ide_req);
        if (ide_req)
            next_mode = chs_pkg::CHS_MODE_IDE;
        else if (c.mode == chs_pkg::CHS_MODE_IDE)
            next_mode = chs_pkg::CHS_MODE_IDE;
        else if (c.io_cfg)
            next_mode = chs_pkg::CHS_MODE_IO;
        else
            next_mode = chs_pkg::CHS_MODE_MEM;
    endfunction

    // configuration write: odd attribute word, memory mode, card ready
    function automatic logic cfg_hit(input chs_card_t c, input logic wr_rise);
        cfg_hit = wr_rise && c.mode == chs_pkg::CHS_MODE_MEM && c.ready && c.addr_latch[0];
    endfunction

    always_comb
    begin
        c_d       = c_q;
        c_d.wr_ev = 1'b0;
        // mode: ide when select low, io once configured, else memory
        c_d.mode = next_mode(c_q, !s_lvl[0] && !selected && c_q.ready);
        // hold write data and address while the strobe is low
        // the last word held before the rising edge is the one written
        if (!s_lvl[2])
        begin
            c_d.wr_latch   = BUS.data_bus;
            c_d.addr_latch = BUS.addr;
        end
        // io strobes only count outside memory mode
        // the event carries the latched word, never the live bus
        if (s_rise[2] && io_like && selected && c_q.ready)
        begin
            c_d.wr_ev   = 1'b1;
            c_d.wr_addr = c_q.addr_latch;
            c_d.wr_data = c_q.wr_latch;
            c_d.mem[c_q.addr_latch] = c_q.wr_latch;
        end
        // configuration write, kept to the odd attribute word so that
        // io writes to even words in memory mode stay ignored
        if (cfg_hit(c_q, s_rise[2] && selected && !BUS.attr_select_n))
        begin
            c_d.cfg    = c_q.wr_latch;
            c_d.io_cfg = c_q.wr_latch[0];
        end
        // ack and data drive follow the synchronised strobe, so both
        // trail the host by the synchroniser delay on the way in and out
        c_d.ack_n = 1'b1;
        c_d.oe_n  = 1'b1;
        if (rd_io && c_q.mode == chs_pkg::CHS_MODE_IO)
        begin
            c_d.ack_n = 1'b0;
        end
        if (rd_io || rd_oe)
        begin
            c_d.oe_n = 1'b0;
        end
        c_d.dout  = rd_word(c_q, BUS.attr_select_n, !rd_io);
        // reset pin: a level held from power-up is treated as absent; a host
        // that releases it only late has lost its pin reset
        if (!BUS.reset_pin)
        begin
            c_d.reset_seen_low = 1'b1;
        end
        if (!c_q.reset_seen_low && !c_q.reset_dis)
        begin
            if (c_q.stuck_cnt == 13'(chs_pkg::STUCK_CYCLES))
            begin
                c_d.reset_dis = 1'b1;
            end
            else
            begin
                c_d.stuck_cnt = step13(c_q.stuck_cnt);
            end
        end
        // a pin reset restarts the busy period and drops the io configuration
        if (BUS.reset_pin && c_q.reset_seen_low && !c_q.reset_dis)
        begin
            c_d.busy_cnt = '0;
            c_d.ready    = 1'b0;
            c_d.io_cfg   = 1'b0;
            c_d.mode     = chs_pkg::CHS_MODE_MEM;
        end
        else if (!c_q.ready)
        begin
            // busy until reset processing done
            if (c_q.busy_cnt == 13'(chs_pkg::BUSY_CYCLES))
            begin
                c_d.ready = 1'b1;
            end
            else
            begin
                c_d.busy_cnt = step13(c_q.busy_cnt);
            end
        end
        // power-up reset wins over everything above
        if (!RST_N)
        begin
            c_d = '0;
            c_d.ack_n = 1'b1;
            c_d.oe_n  = 1'b1;
            c_d.attr  = chs_pkg::ATTR_RESET;
            c_d.cfg   = chs_pkg::CFG_RESET;
            for (int i = 0; i < chs_pkg::DEPTH; i++)
            begin
                c_d.mem[i] = chs_pkg::MEM_RESET;
            end
        end
    end

    // whole card state in one register stage
    always_ff @(posedge MCLK)
    begin
        c_q <= c_d;
    end

    // card answers straight from flops
    assign BUS.input_ack_n    = c_q.ack_n;
    assign BUS.data_card_oe_n = c_q.oe_n;
    assign BUS.data_card_out  = c_q.dout;
    assign BUS.ready          = c_q.ready;
    assign MODE     = c_q.mode;
    assign WR_EVENT = c_q.wr_ev;
    assign WR_ADDR  = c_q.wr_addr;
    assign WR_DATA  = c_q.wr_data;
endmodule

// [hw/chs_host.sv]
// host end: generates memory and io strobes toward the card
module chs_host (
    input  wire logic  MCLK,       // system clock
    input  wire logic  RST_N,      // synchronous reset, active low
    chs_if.host        BUS,        // card side pins
    input  wire logic  REQ,        // level: start a cycle when idle
    input  wire logic [1:0] OP,    // chs_op_t cycle kind
    input  wire logic  IDE,        // select ide mode
    input  wire logic  CARD_RESET, // drive card reset pin high
    input  wire logic [3:0] ADDR,  // cycle address
    input  wire logic [15:0] WDATA,// write data
    output logic       BUSY,       // cycle in progress
    output logic       DONE,       // pulse: cycle finished
    output logic [15:0] RDATA,     // read data
    output logic       ACK_SEEN    // input ack seen during last cycle
);
    typedef struct packed {
        chs_pkg::chs_hstate_t st;
        chs_pkg::chs_op_t     op;
        logic [3:0]  cnt;
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        ce_n, reg_n, oe_n, rd_n, wr_n, d_oe_n, rst, done, ack;
    } chs_host_t;
    chs_host_t h_q, h_d;

    always_comb
    begin
        h_d      = h_q;
        h_d.done = 1'b0;
        h_d.rst  = CARD_RESET;
        unique case (h_q.st)
            chs_pkg::CHS_H_IDLE:
                if (REQ && BUS.ready)
                begin
                    h_d.op    = chs_pkg::chs_op_t'(OP);
                    h_d.addr  = ADDR;
                    h_d.wdata = WDATA;
                    h_d.ce_n  = 1'b0;
                    h_d.reg_n = !(OP == chs_pkg::CHS_OP_ATTRD || OP[1]);
                    h_d.d_oe_n = !(OP == chs_pkg::CHS_OP_IO_WRITE_STROBE_N);
                    h_d.cnt   = '0;
                    h_d.st    = chs_pkg::CHS_H_SETUP;
                end
            chs_pkg::CHS_H_SETUP:
            begin
                h_d.oe_n = !(h_q.op == chs_pkg::CHS_OP_MEMRD || h_q.op == chs_pkg::CHS_OP_ATTRD);
                h_d.rd_n = !(h_q.op == chs_pkg::CHS_OP_IO_READ_STROBE_N);
                h_d.wr_n = !(h_q.op == chs_pkg::CHS_OP_IO_WRITE_STROBE_N);
                h_d.ack  = 1'b0;
                h_d.st   = chs_pkg::CHS_H_PULSE;
            end
            chs_pkg::CHS_H_PULSE:
            begin
                if (!BUS.input_ack_n && !IDE)
                    h_d.ack = 1'b1;
                h_d.rdata = BUS.data_bus;
                if (h_q.cnt == 4'(chs_pkg::HOLD_CYCLES * 2))
                begin
                    h_d.oe_n = 1'b1;
                    h_d.rd_n = 1'b1;
                    h_d.wr_n = 1'b1;
                    h_d.cnt  = '0;
                    h_d.st   = chs_pkg::CHS_H_HOLD;
                end
                else
                    h_d.cnt = h_q.cnt + 4'h1;
            end
            chs_pkg::CHS_H_HOLD:
                if (h_q.cnt == 4'(chs_pkg::HOLD_CYCLES))
                begin
                    h_d.ce_n   = 1'b1;
                    h_d.reg_n  = 1'b1;
                    h_d.d_oe_n = 1'b1;
                    h_d.st     = chs_pkg::CHS_H_DONE;
                end
                else
                    h_d.cnt = h_q.cnt + 4'h1;
            chs_pkg::CHS_H_DONE:
            begin
                h_d.done = 1'b1;
                h_d.st   = chs_pkg::CHS_H_IDLE;
            end
            default:
                h_d.st = chs_pkg::CHS_H_IDLE;
        endcase
        // ide select stays low through whole cycles, not only between them
        if (IDE)
            h_d.oe_n = 1'b0;
        else if (h_q.st == chs_pkg::CHS_H_IDLE)
            h_d.oe_n = 1'b1;
        if (!RST_N)
        begin
            h_d = '0;
            h_d.st = chs_pkg::CHS_H_IDLE;
            {h_d.ce_n, h_d.reg_n, h_d.oe_n, h_d.rd_n, h_d.wr_n, h_d.d_oe_n} = 6'h3f;
        end
    end

    always_ff @(posedge MCLK)
    begin
        h_q <= h_d;
    end

    // both enables select a word cycle
    assign BUS.card_enable_even_n = h_q.ce_n;
    assign BUS.card_enable_odd_n  = h_q.ce_n;
    assign BUS.attr_select_n      = h_q.reg_n;
    assign BUS.output_enable_n    = h_q.oe_n;
    assign BUS.io_read_strobe_n   = h_q.rd_n;
    assign BUS.io_write_strobe_n  = h_q.wr_n;
    assign BUS.addr               = h_q.addr;
    assign BUS.data_host_out      = h_q.wdata;
    assign BUS.data_host_oe_n     = h_q.d_oe_n;
    assign BUS.reset_pin          = h_q.rst;
    assign BUSY     = h_q.st != chs_pkg::CHS_H_IDLE;
    assign DONE     = h_q.done;
    assign RDATA    = h_q.rdata;
    assign ACK_SEEN = h_q.ack;
endmodule

// [verif/chs_monitor.sv]
// concurrent checks on the wires between host and card ends
module chs_monitor (
    input wire logic MCLK,               // system clock
    input wire logic RST_N,              // synchronous reset, active low
    input wire logic card_enable_even_n, // even byte enable
    input wire logic card_enable_odd_n,  // odd byte enable
    input wire logic attr_select_n,      // attribute space select
    input wire logic output_enable_n,    // output enable, also ide select
    input wire logic io_read_strobe_n,   // io read strobe
    input wire logic io_write_strobe_n,  // io write strobe
    input wire logic data_host_oe_n,     // host data drive enable
    input wire logic data_card_oe_n,     // card data drive enable
    input wire logic input_ack_n,        // input acknowledge
    input wire logic ready,              // card ready
    input wire logic reset_pin           // card reset pin, high resets
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] rd_age_q; // cycles since read strobe low
    logic [2:0] oe_age_q; // cycles since output enable low

    // ages allow for the card's synchroniser before it lets go of the bus
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            rd_age_q <= 3'h7;
            oe_age_q <= 3'h7;
        end
        else
        begin
            rd_age_q <= !io_read_strobe_n ? 3'h0 : (rd_age_q == 3'h7 ? rd_age_q : rd_age_q + 3'h1);
            oe_age_q <= !output_enable_n ? 3'h0 : (oe_age_q == 3'h7 ? oe_age_q : oe_age_q + 3'h1);
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    property p_ack_on_read; !input_ack_n |-> rd_age_q < 3'h5; endproperty
    a_ack_on_read: assert property (p_ack_on_read) else $error("ack without read");
    property p_ack_selected; !input_ack_n |-> (!card_enable_even_n || !card_enable_odd_n); endproperty
    a_ack_selected: assert property (p_ack_selected) else $error("ack while unselected");
    property p_ack_host_off; !input_ack_n |-> data_host_oe_n; endproperty
    a_ack_host_off: assert property (p_ack_host_off) else $error("host drives during ack");
    property p_drive_on_strobe; !data_card_oe_n |-> (rd_age_q < 3'h5 || oe_age_q < 3'h5); endproperty
    a_drive_on_strobe: assert property (p_drive_on_strobe) else $error("card drives unasked");
    property p_sync_delay; $fell(io_read_strobe_n) |-> input_ack_n ##1 input_ack_n; endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("ack before sync");
    property p_ready_busy; $rose(RST_N) |-> !ready [*8]; endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready early after reset");
    property p_ready_time; $rose(RST_N) |-> ##[60:70] ready; endproperty
    a_ready_time: assert property (p_ready_time) else $error("ready late after reset");
    property p_pin_reset; $rose(reset_pin) |-> ##[1:6] !ready; endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin not busy");
    property p_no_access_busy; !ready |-> (card_enable_even_n && card_enable_odd_n); endproperty
    a_no_access_busy: assert property (p_no_access_busy) else $error("access while busy");
    property p_io_attr_low; (!io_write_strobe_n && output_enable_n) |-> !attr_select_n; endproperty
    a_io_attr_low: assert property (p_io_attr_low) else $error("attr select high in io");
    property p_write_pulse; $fell(io_write_strobe_n) |-> !io_write_strobe_n [*8]; endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write strobe short");
endmodule

// [verif/card_host_strobe_interface_tb_top.sv]
// self-checking bench: host end drives card end across the strobe wires
module card_host_strobe_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        rst_n;
    logic        req;
    logic [1:0]  op;
    logic        ide;
    logic        card_reset;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    logic        ack_seen;
    logic [1:0]  mode;
    logic        wr_event;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;
    int          num_errors = 0;
    int          tests_run = 0;
    int          wr_events = 0;
    int          cyc = 0;

    chs_if bus();
    chs_if stuck_bus();

    chs_host chs_host_i (.MCLK(mclk), .RST_N(rst_n), .BUS(bus), .REQ(req), .OP(op), .IDE(ide),
        .CARD_RESET(card_reset), .ADDR(addr), .WDATA(wdata), .BUSY(), .DONE(done), .RDATA(rdata),
        .ACK_SEEN(ack_seen));
    chs_card chs_card_i (.MCLK(mclk), .RST_N(rst_n), .BUS(bus), .MODE(mode), .WR_EVENT(wr_event),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data));
    // second card whose reset pin is held high from power-up by the bench
    chs_card chs_card_stuck_i (.MCLK(mclk), .RST_N(rst_n), .BUS(stuck_bus), .MODE(), .WR_EVENT(),
        .WR_ADDR(), .WR_DATA());
    chs_monitor chs_monitor_i (.MCLK(mclk), .RST_N(rst_n), .card_enable_even_n(bus.card_enable_even_n),
        .card_enable_odd_n(bus.card_enable_odd_n), .attr_select_n(bus.attr_select_n),
        .output_enable_n(bus.output_enable_n), .io_read_strobe_n(bus.io_read_strobe_n),
        .io_write_strobe_n(bus.io_write_strobe_n), .data_host_oe_n(bus.data_host_oe_n),
        .data_card_oe_n(bus.data_card_oe_n), .input_ack_n(bus.input_ack_n), .ready(bus.ready),
        .reset_pin(bus.reset_pin));

    // idle host on the second card: strobes high, reset asserted throughout
    assign stuck_bus.card_enable_even_n = 1'b1;
    assign stuck_bus.card_enable_odd_n  = 1'b1;
    assign stuck_bus.attr_select_n      = 1'b1;
    assign stuck_bus.output_enable_n    = 1'b1;
    assign stuck_bus.io_read_strobe_n   = 1'b1;
    assign stuck_bus.io_write_strobe_n  = 1'b1;
    assign stuck_bus.addr               = 4'h0;
    assign stuck_bus.data_host_out      = 16'h0000;
    assign stuck_bus.data_host_oe_n     = 1'b1;
    assign stuck_bus.reset_pin          = 1'b1;

    always #2 mclk = ~mclk;

    // count write events; the strobe must already be back high when one lands
    always @(posedge mclk)
    begin
        if (rst_n)
            cyc++;
        if (wr_event === 1'b1)
        begin
            wr_events++;
            chk("strobe_high_at_write", 16'h1, 16'(bus.io_write_strobe_n));
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results;
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one host cycle, entered and left at a falling edge; done is bounded
    task automatic run_cycle(input logic [1:0] kind, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        op = kind;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(negedge mclk);
        req = 1'b0;
        while (done !== 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk("cycle_done", 16'h1, 16'(done));
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (bus.ready !== 1'b1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic t_power_up;
        int n;
        wait_ready(n);
        chk("ready_delay", 16'h1, 16'(n >= chs_pkg::BUSY_CYCLES - 1 && n <= chs_pkg::BUSY_CYCLES + 2));
    endtask

    task automatic t_mem_mode;
        int n0;
        run_cycle(chs_pkg::CHS_OP_MEMRD, 4'h0, 16'h0000);
        chk("mem_read", chs_pkg::MEM_RESET, rdata);
        run_cycle(chs_pkg::CHS_OP_ATTRD, 4'h0, 16'h0000);
        chk("attr_read", chs_pkg::ATTR_RESET, rdata);
        n0 = wr_events;
        run_cycle(chs_pkg::CHS_OP_IO_WRITE_STROBE_N, 4'h2, 16'h5555);
        chk("io_write_ignored", 16'(n0), 16'(wr_events));
        run_cycle(chs_pkg::CHS_OP_IO_READ_STROBE_N, 4'h2, 16'h0000);
        chk("ack_unused", 16'h0, 16'(ack_seen));
        chk("mode_mem", 16'(chs_pkg::CHS_MODE_MEM), 16'(mode));
    endtask

    // back-to-back writes, then read back with acknowledge
    task automatic t_io_mode;
        int n0;
        run_cycle(chs_pkg::CHS_OP_IO_WRITE_STROBE_N, 4'h1, 16'h0001);
        chk("mode_io", 16'(chs_pkg::CHS_MODE_IO), 16'(mode));
        n0 = wr_events;
        run_cycle(chs_pkg::CHS_OP_IO_WRITE_STROBE_N, 4'h4, 16'h1234);
        chk("wr_data_a", 16'h1234, wr_data);
        run_cycle(chs_pkg::CHS_OP_IO_WRITE_STROBE_N, 4'h8, 16'hbeef);
        chk("wr_count", 16'(n0 + 2), 16'(wr_events));
        chk("wr_addr_b", 16'h0008, 16'(wr_addr));
        chk("wr_data_b", 16'hbeef, wr_data);
        run_cycle(chs_pkg::CHS_OP_IO_READ_STROBE_N, 4'h4, 16'h0000);
        chk("io_read", 16'h1234, rdata);
        chk("io_ack", 16'h1, 16'(ack_seen));
        run_cycle(chs_pkg::CHS_OP_ATTRD, 4'h0, 16'h0000);
        chk("io_attr_read", chs_pkg::ATTR_RESET, rdata);
        run_cycle(chs_pkg::CHS_OP_MEMRD, 4'h0, 16'h0000);
        chk("io_mem_read", 16'h0000, rdata);
    endtask

    task automatic t_ide;
        ide = 1'b1;
        repeat (8) @(negedge mclk);
        chk("mode_ide", 16'(chs_pkg::CHS_MODE_IDE), 16'(mode));
        run_cycle(chs_pkg::CHS_OP_IO_WRITE_STROBE_N, 4'h6, 16'habcd);
        chk("ide_wr_data", 16'habcd, wr_data);
        run_cycle(chs_pkg::CHS_OP_IO_READ_STROBE_N, 4'h6, 16'h0000);
        chk("ide_read", 16'habcd, rdata);
        chk("ide_no_ack", 16'h0, 16'(ack_seen));
    endtask

    task automatic t_reset_pin;
        int n;
        ide = 1'b0;
        card_reset = 1'b1;
        repeat (8) @(negedge mclk);
        chk("pin_busy", 16'h0, 16'(bus.ready));
        card_reset = 1'b0;
        wait_ready(n);
        chk("pin_ready", 16'h1, 16'(bus.ready));
        chk("pin_mode_mem", 16'(chs_pkg::CHS_MODE_MEM), 16'(mode));
    endtask

    // reset pin held from power-up must stop counting as a reset
    task automatic t_stuck;
        while (cyc < chs_pkg::STUCK_CYCLES + 200)
            @(negedge mclk);
        chk("stuck_ready", 16'h1, 16'(stuck_bus.ready));
    endtask

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        req = 1'b0;
        op = 2'h0;
        ide = 1'b0;
        card_reset = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        t_power_up();
        t_mem_mode();
        t_io_mode();
        t_ide();
        t_reset_pin();
        t_stuck();
        results();
    end

    // watchdog well beyond the stuck reset wait
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        results();
    end
endmodule
